// file: hw/lbiu_consts.svh
// Constants for the local bus interface unit
// Summary of operation
// RULE1 - Drive 20-bit address, read/write strobes, status, and write data.
// RULE2 - Capture bus data during a read cycle.
// RULE3 - Cycles last at least four states; slave stretches via ready inputs.
// RULE4 - Drive transceiver enable and transmit/receive direction outputs.
// RULE5 - Grant bus to another master via hold request and grant ack.
// RULE6 - Divide the input clock by two for all processor timing.
// RULE7 - Processor clock output has a 50% duty cycle.
// RULE8 - Powerdown halts all operation and stops the clock circuits.
// RULE9 - Float bus outputs while granted; resume only after hold is withdrawn.
`ifndef LBIU_CONSTS_SVH
`define LBIU_CONSTS_SVH
`define LBIU_ADDR_W 20
`define LBIU_DATA_W 16
`define LBIU_MIN_STATES 4
`define LBIU_STAT_IDLE 3'h7
`define LBIU_STAT_READ 3'h5
`define LBIU_STAT_WRITE 3'h6
`endif

// file: hw/lbiu_pkg.sv
// Types for the local bus interface unit
package lbiu_pkg;
    typedef enum logic [5:0] {
        LBIU_IDLE = 6'h01,
        LBIU_T1 = 6'h02,
        LBIU_T2 = 6'h04,
        LBIU_T3 = 6'h08,
        LBIU_T4 = 6'h10,
        LBIU_HOLD = 6'h20
    } lbiu_state_type;
endpackage : lbiu_pkg

// file: hw/lbiu_clkdiv.sv
// Divide-by-two phase generator with powerdown freeze
module lbiu_clkdiv (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_powerdown,
    output logic o_phase,
    output logic o_tick
);
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_phase <= 1'b0;
        end else if (!i_powerdown) begin
            o_phase <= ~o_phase; // RULE6 RULE7
        end
    end

    // One state per two input clocks; frozen in powerdown
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_tick <= 1'b0;
        end else begin
            o_tick <= !i_powerdown && o_phase; // RULE6 RULE8
        end
    end
endmodule : lbiu_clkdiv

// file: hw/lbiu_top.sv
// Local bus interface unit: bus cycle engine, hold and clock output
`include "lbiu_consts.svh"
module lbiu_top (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_powerdown,
    input wire logic i_req,
    input wire logic i_req_write,
    input wire logic [19:0] i_req_addr,
    input wire logic [15:0] i_req_wdata,
    input wire logic i_sync_ready_in,
    input wire logic i_async_ready_in,
    input wire logic i_hold_req,
    input wire logic [15:0] i_ad_in,
    output logic o_req_done,
    output logic [15:0] o_rdata,
    output logic [19:0] o_addr,
    output logic o_addr_oe,
    output logic [15:0] o_ad_out,
    output logic o_ad_oe,
    output logic o_rd_n,
    output logic o_wr_n,
    output logic o_strobe_oe,
    output logic [2:0] o_status,
    output logic o_transceiver_enable_n,
    output logic o_transmit_receive_dir,
    output logic o_bus_grant_ack,
    output logic o_processor_clock_out
);
    import lbiu_pkg::*;

    lbiu_state_type state_r;
    logic phase;
    logic tick;
    logic wr_r;
    logic async_s1_r;
    logic async_s2_r;
    logic ready;

    lbiu_clkdiv u_div (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_powerdown(i_powerdown),
        .o_phase(phase),
        .o_tick(tick)
    );

    // Async ready is brought through two flops before use
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            async_s1_r <= 1'b0;
            async_s2_r <= 1'b0;
        end else begin
            async_s1_r <= i_async_ready_in;
            async_s2_r <= async_s1_r;
        end
    end

    assign ready = i_sync_ready_in || async_s2_r; // RULE3

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_processor_clock_out <= 1'b0;
        end else begin
            o_processor_clock_out <= phase; // RULE7
        end
    end

    // Bus state sequence; advances only on processor ticks
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            state_r <= LBIU_IDLE;
            wr_r <= 1'b0;
        end else if (tick) begin // RULE8
            case (state_r)
                LBIU_IDLE: begin
                    if (i_hold_req) begin
                        state_r <= LBIU_HOLD; // RULE5
                    end else if (i_req) begin
                        state_r <= LBIU_T1;
                        wr_r <= i_req_write;
                    end
                end
                LBIU_T1: state_r <= LBIU_T2;
                LBIU_T2: state_r <= LBIU_T3;
                LBIU_T3: begin
                    if (ready) begin
                        state_r <= LBIU_T4; // RULE3
                    end
                end
                LBIU_T4: state_r <= LBIU_IDLE;
                LBIU_HOLD: begin
                    if (!i_hold_req) begin
                        state_r <= LBIU_IDLE; // RULE9
                    end
                end
                default: state_r <= LBIU_IDLE;
            endcase
        end
    end

    // Address latched at T1 and held through the cycle
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_addr <= '0;
            o_ad_out <= '0;
        end else if (tick && state_r == LBIU_IDLE && i_req &&
                !i_hold_req) begin
            o_addr <= i_req_addr; // RULE1
            o_ad_out <= i_req_wdata; // RULE1
        end
    end

    // Strobes, status and transceiver controls follow the current state one clock later
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_rd_n <= 1'b1;
            o_wr_n <= 1'b1;
            o_status <= `LBIU_STAT_IDLE;
            o_transceiver_enable_n <= 1'b1;
            o_transmit_receive_dir <= 1'b1;
            o_ad_oe <= 1'b0;
        end else begin
            o_rd_n <= !(!wr_r && (state_r == LBIU_T2 || state_r == LBIU_T3));
            o_wr_n <= !(wr_r && (state_r == LBIU_T2 || state_r == LBIU_T3));
            o_status <= (state_r == LBIU_T1 || state_r == LBIU_T2 ||
                state_r == LBIU_T3) ? (wr_r ? `LBIU_STAT_WRITE :
                `LBIU_STAT_READ) : `LBIU_STAT_IDLE; // RULE1
            o_transceiver_enable_n <= !(state_r == LBIU_T2 ||
                state_r == LBIU_T3); // RULE4
            o_transmit_receive_dir <= (state_r == LBIU_HOLD) ? 1'b1 :
                (state_r == LBIU_IDLE) ? 1'b1 : wr_r; // RULE4
            o_ad_oe <= wr_r && (state_r == LBIU_T2 ||
                state_r == LBIU_T3); // RULE1
        end
    end

    // Bus owned except while granted away
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_bus_grant_ack <= 1'b0;
            o_addr_oe <= 1'b1;
            o_strobe_oe <= 1'b1;
        end else begin
            o_bus_grant_ack <= (state_r == LBIU_HOLD); // RULE5
            o_addr_oe <= (state_r != LBIU_HOLD); // RULE9
            o_strobe_oe <= (state_r != LBIU_HOLD); // RULE9
        end
    end

    // Read data captured at the T3 tick that ends the wait
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_rdata <= '0;
            o_req_done <= 1'b0;
        end else begin
            o_req_done <= tick && state_r == LBIU_T3 && ready;
            if (tick && state_r == LBIU_T3 && ready && !wr_r) begin
                o_rdata <= i_ad_in; // RULE2
            end
        end
    end

    int unsigned cyc_cnt;
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || state_r == LBIU_IDLE) begin
            cyc_cnt <= 0;
        end else if (tick) begin
            cyc_cnt <= cyc_cnt + 1;
        end
    end

    sequence s_cycle_end;
        tick && state_r == LBIU_T4;
    endsequence

    AST_MIN_STATES: assert property (@(posedge i_ref_clk) // RULE3
        disable iff (i_reset) s_cycle_end |-> cyc_cnt >= `LBIU_MIN_STATES - 1)
        else $error("bus cycle shorter than four states");
    AST_WAIT_READY: assert property (@(posedge i_ref_clk) // RULE3
        disable iff (i_reset) tick && state_r == LBIU_T3 && !ready
        |=> state_r == LBIU_T3)
        else $error("T3 left without ready");
    AST_HOLD_FLOAT: assert property (@(posedge i_ref_clk) // RULE9
        disable iff (i_reset) o_bus_grant_ack |-> !o_addr_oe && !o_ad_oe
        && !o_strobe_oe)
        else $error("bus driven while granted");
    AST_GRANT: assert property (@(posedge i_ref_clk) // RULE5
        disable iff (i_reset) tick && state_r == LBIU_IDLE && i_hold_req
        |=> ##1 o_bus_grant_ack)
        else $error("hold not granted");
    AST_RESUME: assert property (@(posedge i_ref_clk) // RULE9
        disable iff (i_reset) state_r == LBIU_HOLD && i_hold_req
        |=> state_r == LBIU_HOLD)
        else $error("hold left while still requested");
    // Clock output lags the phase by one edge, so look two edges back
    AST_DIV2: assert property (@(posedge i_ref_clk) // RULE7
        disable iff (i_reset) !$past(i_powerdown, 2) && !$past(i_reset, 2)
        |-> o_processor_clock_out != $past(o_processor_clock_out))
        else $error("clock output not divided by two");

    // A tick or phase launched just before powerdown still lands
    sequence s_pdown_settled;
        i_powerdown ##2 1'b1;
    endsequence

    AST_PDOWN: assert property (@(posedge i_ref_clk) // RULE8
        disable iff (i_reset) s_pdown_settled |-> $stable(state_r))
        else $error("state moved in powerdown");
    AST_CLK_FROZEN: assert property (@(posedge i_ref_clk) // RULE8
        disable iff (i_reset) s_pdown_settled
        |-> $stable(o_processor_clock_out))
        else $error("clock output ran in powerdown");
    AST_TICK_SPACING: assert property (@(posedge i_ref_clk) // RULE6
        disable iff (i_reset) tick |=> !tick)
        else $error("processor state shorter than two clocks");
    AST_STROBE_EXCL: assert property (@(posedge i_ref_clk) // RULE1
        disable iff (i_reset) !o_rd_n |-> o_wr_n)
        else $error("read and write strobes both active");
    AST_RD_DIR: assert property (@(posedge i_ref_clk) // RULE4
        disable iff (i_reset) !o_rd_n |-> !o_transmit_receive_dir
        && !o_transceiver_enable_n)
        else $error("transceiver not set for read");
    AST_READ_CAP: assert property (@(posedge i_ref_clk) // RULE2
        disable iff (i_reset) tick && state_r == LBIU_T3 && ready && !wr_r
        |=> o_rdata == $past(i_ad_in))
        else $error("read data not captured");
    AST_WR_DIR: assert property (@(posedge i_ref_clk) // RULE4
        disable iff (i_reset) !o_wr_n |-> o_transmit_receive_dir
        && !o_transceiver_enable_n)
        else $error("transceiver not set for write");
endmodule : lbiu_top

// file: verif/lbiu_slave_model.sv
// Bus slave: sixteen-word memory with programmable wait states
module lbiu_slave_model (
    input wire logic i_ref_clk,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic [19:0] i_addr,
    input wire logic [15:0] i_ad_out,
    input wire logic [3:0] i_waits,
    input wire logic i_use_async,
    output logic [15:0] o_ad_in,
    output logic o_sync_ready_in,
    output logic o_async_ready_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:15];
    logic [4:0] cnt;
    logic rdy;
    initial begin
        cnt = 5'h00;
        o_ad_in = 16'h0000;
    end
    // Two reference cycles per wait state, counted while a strobe is low
    assign rdy = (cnt >= {i_waits, 1'b0});
    assign o_sync_ready_in = rdy & ~i_use_async;
    assign o_async_ready_in = rdy & i_use_async;
    always @(posedge i_ref_clk) begin
        cnt <= (i_rd_n & i_wr_n) ? 5'h00 : cnt + 5'h01;
        if (!i_wr_n)
            mem[i_addr[3:0]] <= i_ad_out;
        // Outside a read the bus toggles each clock between the last value and its complement
        o_ad_in <= !i_rd_n ? mem[i_addr[3:0]] : ~o_ad_in;
    end
endmodule : lbiu_slave_model

// file: verif/local_bus_interface_unit_tb_top.sv
// Self-checking bench for the local bus interface unit
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module local_bus_interface_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic wr; logic [19:0] a; logic [15:0] d;
        logic [3:0] w; logic as;} lbiu_row_type;
    logic i_ref_clk, i_reset, i_powerdown, i_req, i_req_write, i_hold_req;
    logic i_sync_ready_in, i_async_ready_in, use_async, c;
    logic [3:0] waits;
    logic [19:0] i_req_addr, o_addr;
    logic [15:0] i_req_wdata, i_ad_in, o_rdata, o_ad_out;
    logic o_req_done, o_addr_oe, o_ad_oe, o_rd_n, o_wr_n, o_strobe_oe;
    logic o_transceiver_enable_n, o_transmit_receive_dir;
    logic o_bus_grant_ack, o_processor_clock_out;
    logic [2:0] o_status;
    int failures = 0;
    int n_tests = 0;
    lbiu_row_type rows [4] = '{'{1, 20'hFFFF3, 16'hBEEF, 0, 0},
        '{0, 20'hFFFF3, 16'hBEEF, 0, 0}, '{1, 20'h00004, 16'h1234, 2, 0},
        '{0, 20'h00004, 16'h1234, 3, 1}};
    lbiu_top i_dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .i_powerdown(i_powerdown), .i_req(i_req), .i_req_write(i_req_write),
        .i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata),
        .i_sync_ready_in(i_sync_ready_in),
        .i_async_ready_in(i_async_ready_in), .i_hold_req(i_hold_req),
        .i_ad_in(i_ad_in), .o_req_done(o_req_done), .o_rdata(o_rdata),
        .o_addr(o_addr), .o_addr_oe(o_addr_oe), .o_ad_out(o_ad_out),
        .o_ad_oe(o_ad_oe), .o_rd_n(o_rd_n), .o_wr_n(o_wr_n),
        .o_strobe_oe(o_strobe_oe), .o_status(o_status),
        .o_transceiver_enable_n(o_transceiver_enable_n),
        .o_transmit_receive_dir(o_transmit_receive_dir),
        .o_bus_grant_ack(o_bus_grant_ack),
        .o_processor_clock_out(o_processor_clock_out));
    lbiu_slave_model i_slave (.i_ref_clk(i_ref_clk), .i_rd_n(o_rd_n),
        .i_wr_n(o_wr_n), .i_addr(o_addr), .i_ad_out(o_ad_out),
        .i_waits(waits), .i_use_async(use_async), .o_ad_in(i_ad_in),
        .o_sync_ready_in(i_sync_ready_in),
        .o_async_ready_in(i_async_ready_in));
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    task automatic run(input lbiu_row_type r);
        int n;
        logic st;
        n = 0;
        st = 1'b0;
        {i_req_write, i_req_addr, i_req_wdata} = {r.wr, r.a, r.d};
        {waits, use_async, i_req} = {r.w, r.as, 1'b1};
        while (o_req_done !== 1'b1 && n < 200) begin
            @(negedge i_ref_clk);
            n++;
            if (o_status === (r.wr ? 3'h6 : 3'h5))
                st = 1'b1;
            if (o_rd_n === 1'b0 || o_wr_n === 1'b0) begin
                `CHK("addr", r.a, o_addr)
                `CHK("wr_n", ~r.wr, o_wr_n)
                `CHK("dir", r.wr, o_transmit_receive_dir)
                `CHK("enable_n", 1'b0, o_transceiver_enable_n)
                if (r.wr) `CHK("wdata", r.d, o_ad_out)
                `CHK("ad_oe", r.wr, o_ad_oe)
                `CHK("bus_oe", 2'h3, {o_addr_oe, o_strobe_oe})
            end
        end
        i_req = 1'b0;
        if (n >= 200) begin
            failures++;
            stop_test();
        end
        `CHK("status", 1'b1, st)
        `CHK("length", 1'b1, n >= 6 + r.w)
        if (!r.wr) `CHK("rdata", r.d, o_rdata)
        // Let the done pulse pass so a following call does not see it
        @(negedge i_ref_clk);
    endtask : run
    task automatic wait_ack(input logic v);
        int n;
        n = 0;
        while (o_bus_grant_ack !== v && n < 40) begin
            @(negedge i_ref_clk);
            n++;
        end
        `CHK("grant", v, o_bus_grant_ack)
        if (o_bus_grant_ack !== v) stop_test();
    endtask : wait_ack
    initial begin
        {i_reset, i_powerdown, i_req, i_req_write, i_hold_req} = 5'h10;
        {i_req_addr, i_req_wdata, waits, use_async} = '0;
        repeat (10) @(negedge i_ref_clk);
        `CHK("rst_rd", 1'b1, o_rd_n)
        `CHK("rst_status", 3'h7, o_status)
        `CHK("rst_grant", 1'b0, o_bus_grant_ack)
        i_reset = 1'b0;
        foreach (rows[i]) run(rows[i]);
        $display("table rows done");
        c = o_processor_clock_out;
        repeat (4) begin
            @(negedge i_ref_clk);
            `CHK("clk_out", ~c, o_processor_clock_out)
            c = o_processor_clock_out;
        end
        i_powerdown = 1'b1;
        @(negedge i_ref_clk);
        c = o_processor_clock_out;
        repeat (3) begin
            @(negedge i_ref_clk);
            `CHK("frozen", c, o_processor_clock_out)
        end
        i_powerdown = 1'b0;
        $display("clock tests done");
        i_hold_req = 1'b1;
        wait_ack(1'b1);
        i_req = 1'b1;
        repeat (8) begin
            @(negedge i_ref_clk);
            `CHK("float", 3'h0, {o_addr_oe, o_ad_oe, o_strobe_oe})
            `CHK("no_done", 1'b0, o_req_done)
        end
        i_hold_req = 1'b0;
        wait_ack(1'b0);
        run(rows[1]);
        $display("hold test done");
        i_req = 1'b1;
        repeat (7) @(negedge i_ref_clk);
        `CHK("mid_rd_n", 1'b0, o_rd_n)
        {i_reset, i_req} = 2'h2;
        repeat (2) @(negedge i_ref_clk);
        `CHK("mid_rst", 5'h1F, {o_rd_n, o_wr_n, o_status})
        `CHK("mid_den", 2'h2, {o_transceiver_enable_n, o_bus_grant_ack})
        i_reset = 1'b0;
        run(rows[1]);
        $display("reset test done");
        stop_test();
    end
endmodule : local_bus_interface_unit_tb_top
